// ---- sadc_clk_div.sv ----
/*
 * converter clock prescaler: produces the converter clock and a tick on
 * each of its falling edges from mclk.
 * assumes the prescaler code stays stable while enabled.
 */
`default_nettype none

module sadc_clk_div (
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic       run,
	input  wire logic [2:0] prescale,
	output logic            convClk,
	output logic            fallTick
);

	// ------------------------------------------------------------
	// divider
	// ------------------------------------------------------------
	logic [3:0] halfCnt;
	logic [3:0] halfLen;
	logic       divOne;

	always_comb begin
		halfLen = sadc_pkg::sadc_half(prescale);
		divOne  = (prescale == 3'h1);
	end

	always_ff @(posedge mclk) begin
		if (!rst_n || !run || halfLen == 4'h0) begin // [R9] [R10]
			halfCnt  <= 4'h0;
			convClk  <= 1'b1;
			fallTick <= 1'b0;
		end else if (divOne) begin
			// divide by one: every mclk is one converter clock
			convClk  <= 1'b1;
			fallTick <= 1'b1;
		end else if (halfCnt == halfLen - 4'h1) begin // [R9]
			halfCnt  <= 4'h0;
			convClk  <= !convClk;
			fallTick <= convClk;
		end else begin
			halfCnt  <= halfCnt + 4'h1;
			fallTick <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// ---- sadc_pkg.sv ----
/*
 * package of the converter sequencer: register offsets, control fields,
 * reset values, prescaler table, sequence counts, bus response codes, control and analog structs.
 * assumes a single synchronous clock domain and an AXI4-Lite register bus.
 */
// Behaviour
// R1 - single mode: one conversion of the selected input, then stop.
// R2 - continuous mode: keep converting; result read returns last completed value at once.
// R3 - reset clears control register and powers converter down; result undefined.
// R4 - control: channel bits 7..5, mode bits 4..3, prescaler bits 2..0.
// R5 - accepted control write starts a sequence; result goes to result register.
// R6 - single-ended: channel code n routes input n to positive input.
// R7 - differential: even n pairs with n+1, odd n pairs with n-1 negative.
// R8 - mode 00 se single, 01 se scan, 10 diff single, 11 diff scan.
// R9 - prescaler 000 inhibits clock; 001..111 divide by 1,2,4,6,12,8,16.
// R10 - write with zero prescaler starts nothing, stops clock, powers down.
// R11 - power up at write; sample two clocks from next falling edge; select midway.
// R12 - single mode: conversion complete powers the converter down.
// R13 - continuous: complete restarts; deselect one converter clock before next sample.
// R14 - load each 8-bit result, never while load strobe is high.
// R15 - while busy, writes change only the busy flag. A write that clears busy with byte 0 enabled also loads control and starts.
// R16 - busy cleared by completion or software; then one write loads and starts.
// R17 - software keeps converter clock between 100 kHz and 1.67 MHz.
// R18 - conversion is twelve clocks: reset, two sample, eight convert, one load.
// R19 - result register is read-only; writes leave it untouched.
// R20 - power-save powers converter down; on exit a running conversion restarts.
// R21 - differential: only positive input sampled; negative stays connected throughout.
// R22 - busy set by starting write; held until complete (single) or software clear.

`default_nettype none

package sadc_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [3:0] SADC_OFS_CONTROL = 4'h0;
	localparam logic [3:0] SADC_OFS_RESULT  = 4'h4;
	localparam logic [3:0] SADC_OFS_STATUS  = 4'h8;

	// ------------------------------------------------------------
	// control field positions and reset values
	// ------------------------------------------------------------
	localparam int         SADC_CHAN_LSB  = 5;
	localparam int         SADC_MODE_LSB  = 3;
	localparam int         SADC_PRE_LSB   = 0;
	localparam int         SADC_BUSY_BIT  = 8;
	localparam logic [7:0] SADC_CTRL_RST  = 8'h00;
	localparam int         SADC_MODE_DIFF = 1;
	localparam int         SADC_MODE_SCAN = 0;

	// ------------------------------------------------------------
	// sequence counts in converter clocks and bus response codes
	// ------------------------------------------------------------
	localparam logic [3:0] SADC_CYC_RESET  = 4'h0;
	localparam logic [3:0] SADC_CYC_SAMPLE = 4'h1;
	localparam logic [3:0] SADC_CYC_SMPEND = 4'h2;
	localparam logic [3:0] SADC_CYC_CONVND = 4'hA;
	localparam logic [3:0] SADC_CYC_LOAD   = 4'hB;
	localparam logic [1:0] SADC_BRESP_OK   = 2'h0;
	localparam logic [1:0] SADC_BRESP_ERR  = 2'h2;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [2:0] channel;
		logic [1:0] mode;
		logic [2:0] prescale;
	} sadc_ctrl_type;

	typedef struct packed {
		logic       pwrUp;
		logic       sample;
		logic       select;
		logic       load;
		logic [2:0] posChan;
		logic [2:0] negChan;
		logic       diff;
	} sadc_analog_type;

	typedef enum logic [3:0] {
		SADC_IDLE   = 4'h1,
		SADC_ARM    = 4'h2,
		SADC_RUN    = 4'h4,
		SADC_DESEL  = 4'h8
	} sadc_state_type;

	// half period in mclk cycles per prescaler code, 0 for inhibit
	function automatic logic [3:0] sadc_half(input logic [2:0] code);
		case (code)
			3'h1:    sadc_half = 4'h1;
			3'h2:    sadc_half = 4'h1;
			3'h3:    sadc_half = 4'h2;
			3'h4:    sadc_half = 4'h3;
			3'h5:    sadc_half = 4'h6;
			3'h6:    sadc_half = 4'h4;
			3'h7:    sadc_half = 4'h8;
			default: sadc_half = 4'h0;
		endcase
	endfunction

endpackage

`default_nettype wire

// ---- sadc_seq_sva.sv ----
/*
 * checker of the converter sequencer ports: bus answers, reset, routing.
 * assumes it is bound onto sadc_sequencer in the single mclk domain.
 */
`default_nettype none

module sadc_seq_sva (
	input wire logic                      mclk,
	input wire logic                      rst_n,
	input wire logic [3:0]                s_axi_awaddr,
	input wire logic                      s_axi_awvalid,
	input wire logic                      s_axi_awready,
	input wire logic [1:0]                s_axi_bresp,
	input wire logic                      s_axi_bvalid,
	input wire logic                      s_axi_bready,
	input wire logic [3:0]                s_axi_araddr,
	input wire logic                      s_axi_arvalid,
	input wire logic                      s_axi_arready,
	input wire logic [31:0]               s_axi_rdata,
	input wire logic [1:0]                s_axi_rresp,
	input wire logic                      s_axi_rvalid,
	input wire logic                      s_axi_rready,
	input wire logic                      powerSave,
	input wire sadc_pkg::sadc_analog_type analogCtl,
	input wire logic                      convClk
);
	logic [3:0] lastAw;
	logic [3:0] lastAr;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	// ------------------------------------------------------------
	// taken addresses
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (s_axi_awvalid && s_axi_awready) begin
			lastAw <= s_axi_awaddr;
		end
	end
	always_ff @(posedge mclk) begin
		if (s_axi_arvalid && s_axi_arready) begin
			lastAr <= s_axi_araddr;
		end
	end

	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	reset_clears_a: assert property (disable iff (1'b0)
		!rst_n |=> !analogCtl.pwrUp && !analogCtl.sample && convClk && !s_axi_bvalid)
		else $error("outputs not cleared by reset");
	aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("write address ready held");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
	bresp_code_a: assert property ($rose(s_axi_bvalid) && lastAw[1:0] == 2'b00 |->
		s_axi_bresp == (lastAw == 4'hC ? sadc_pkg::SADC_BRESP_ERR : sadc_pkg::SADC_BRESP_OK))
		else $error("wrong write response");
	rresp_code_a: assert property ($rose(s_axi_rvalid) && lastAr[1:0] == 2'b00 |->
		s_axi_rresp == (lastAr == 4'hC ? sadc_pkg::SADC_BRESP_ERR : sadc_pkg::SADC_BRESP_OK))
		else $error("wrong read response");
	diff_pair_a: assert property (analogCtl.sample && analogCtl.diff |->
		analogCtl.negChan == (analogCtl.posChan ^ 3'h1)) else $error("bad pair");
	sample_power_a: assert property (analogCtl.sample || analogCtl.select |->
		analogCtl.pwrUp) else $error("sampling while powered down");
	sample_stable_a: assert property (analogCtl.sample && $past(analogCtl.sample) |->
		$stable(analogCtl.posChan) && $stable(analogCtl.negChan)) else $error("input moved");
	save_down_a: assert property (powerSave [*6] |-> !analogCtl.pwrUp)
		else $error("powered during power save");
	load_apart_a: assert property (!(analogCtl.sample && analogCtl.load))
		else $error("sample and load overlap");
endmodule

`default_nettype wire

// ---- sadc_sequencer.sv ----
/*
 * converter sequencer top: AXI4-Lite register slave, control register,
 * busy lock, twelve-cycle conversion sequence, channel routing, result.
 * assumes the analog macro returns its result and a complete pulse on
 * mclk, and a power-save level from the power manager.
 */
`default_nettype none

module sadc_sequencer (
	input  wire logic                      mclk,
	input  wire logic                      rst_n,
	input  wire logic [3:0]                s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	output logic [1:0]                     s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	input  wire logic [3:0]                s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	output logic [31:0]                    s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	input  wire logic                      powerSave,
	input  wire logic [7:0]                convData,
	input  wire logic                      convDone,
	output sadc_pkg::sadc_analog_type      analogCtl,
	output logic                           convClk
);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	sadc_pkg::sadc_ctrl_type  conversion_control_reg;
	logic                     converter_busy_flag;
	logic [7:0]               conversion_result_reg;
	sadc_pkg::sadc_state_type state;
	logic [3:0]               cycCnt;
	logic                     fallTick;
	logic                     divClk;
	logic                     divRun;
	logic                     startReq;
	logic                     stopReq;
	logic                     ctrlWrite;
	logic                     busyClear;
	logic                     doneSeen;
	logic [7:0]               heldData;
	logic                     heldNew;
	logic                     seqLive;
	logic [1:0]               psSync;
	logic                     psStage0;
	logic                     psPrev;
	logic                     psExit;
	logic                     loadHigh;
	logic                     awHeld;
	logic                     wHeld;
	logic [3:0]               awAddr;
	logic [31:0]              wData;
	logic [3:0]               wStrb;
	logic                     scanMode;

	// ------------------------------------------------------------
	// power-save input synchroniser
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			psStage0 <= 1'b0;
			psSync   <= 2'b00;
			psPrev   <= 1'b0;
		end else begin
			psStage0 <= powerSave;
			psSync   <= {psSync[0], psStage0};
			if (psSync[1] == psSync[0]) begin
				psPrev <= psSync[1];
			end
		end
	end

	assign psExit = psPrev && (psSync[1] == psSync[0]) && !psSync[1];

	// ------------------------------------------------------------
	// AXI4-Lite write channel
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			awHeld        <= 1'b0;
			wHeld         <= 1'b0;
			awAddr        <= 4'h0;
			wData         <= 32'h00000000;
			wStrb         <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= sadc_pkg::SADC_BRESP_OK;
		end else begin
			s_axi_awready <= !awHeld && !s_axi_awready && !s_axi_bvalid && s_axi_awvalid;
			s_axi_wready  <= !wHeld && !s_axi_wready && !s_axi_bvalid && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld <= 1'b1;
				awAddr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld <= 1'b1;
				wData <= s_axi_wdata;
				wStrb <= s_axi_wstrb;
			end
			if (awHeld && wHeld && !s_axi_bvalid) begin
				s_axi_bvalid <= 1'b1;
				if (awAddr == sadc_pkg::SADC_OFS_CONTROL ||
				    awAddr == sadc_pkg::SADC_OFS_RESULT ||
				    awAddr == sadc_pkg::SADC_OFS_STATUS) begin
					s_axi_bresp <= sadc_pkg::SADC_BRESP_OK;
				end else begin
					s_axi_bresp <= sadc_pkg::SADC_BRESP_ERR;
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				awHeld       <= 1'b0;
				wHeld        <= 1'b0;
			end
		end
	end

	// write commits in the cycle the response is raised; result offset ignored [R19]
	always_comb begin
		ctrlWrite = awHeld && wHeld && !s_axi_bvalid &&
			awAddr == sadc_pkg::SADC_OFS_CONTROL;
		busyClear = ctrlWrite && wStrb[1] && !wData[sadc_pkg::SADC_BUSY_BIT];
		startReq  = ctrlWrite && wStrb[0] && (!converter_busy_flag || busyClear) &&
			wData[2:0] != 3'h0; // [R5] [R16]
		stopReq   = ctrlWrite && wStrb[0] && (!converter_busy_flag || busyClear) &&
			wData[2:0] == 3'h0; // [R10]
	end

	// ------------------------------------------------------------
	// AXI4-Lite read channel
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= sadc_pkg::SADC_BRESP_OK;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= sadc_pkg::SADC_BRESP_OK;
				if (s_axi_araddr == sadc_pkg::SADC_OFS_CONTROL) begin
					s_axi_rdata <= {23'h000000, converter_busy_flag,
						conversion_control_reg};
				end else if (s_axi_araddr == sadc_pkg::SADC_OFS_RESULT) begin
					s_axi_rdata <= {24'h000000, conversion_result_reg}; // [R2]
				end else if (s_axi_araddr == sadc_pkg::SADC_OFS_STATUS) begin
					s_axi_rdata <= {28'h0000000, state};
				end else begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= sadc_pkg::SADC_BRESP_ERR;
				end
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// control register and busy flag
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			conversion_control_reg <= sadc_pkg::SADC_CTRL_RST; // [R3]
		end else if (startReq || stopReq) begin
			conversion_control_reg <= wData[7:0]; // [R4] [R15]
		end
	end

	assign scanMode = conversion_control_reg.mode[sadc_pkg::SADC_MODE_SCAN]; // [R8]

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			converter_busy_flag <= 1'b0;
		end else if (startReq) begin
			converter_busy_flag <= 1'b1; // [R22]
		end else if (busyClear) begin
			converter_busy_flag <= 1'b0; // [R16]
		end else if (doneSeen && !scanMode) begin
			converter_busy_flag <= 1'b0; // [R16] [R22]
		end
	end

	// ------------------------------------------------------------
	// converter clock
	// ------------------------------------------------------------
	assign divRun = (state != sadc_pkg::SADC_IDLE) && !psPrev; // [R20]

	sadc_clk_div u_div (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.run      (divRun),
		.prescale (conversion_control_reg.prescale),
		.convClk  (divClk),
		.fallTick (fallTick)
	);

	// ------------------------------------------------------------
	// sequence state machine
	// ------------------------------------------------------------
	assign doneSeen = !psPrev && (state == sadc_pkg::SADC_RUN) && fallTick &&
		cycCnt == sadc_pkg::SADC_CYC_LOAD;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state  <= sadc_pkg::SADC_IDLE; // [R3]
			cycCnt <= sadc_pkg::SADC_CYC_RESET;
		end else if (stopReq) begin
			state  <= sadc_pkg::SADC_IDLE; // [R10]
			cycCnt <= sadc_pkg::SADC_CYC_RESET;
		end else if (startReq || (psExit && state != sadc_pkg::SADC_IDLE)) begin
			// fall coinciding with end of write skipped by ARM [R11] [R20]
			state  <= sadc_pkg::SADC_ARM;
			cycCnt <= sadc_pkg::SADC_CYC_RESET;
		end else if (!psPrev && fallTick) begin
			case (state)
				sadc_pkg::SADC_ARM: begin
					state  <= sadc_pkg::SADC_RUN; // [R11]
					cycCnt <= sadc_pkg::SADC_CYC_SAMPLE;
				end
				sadc_pkg::SADC_RUN: begin
					if (cycCnt == sadc_pkg::SADC_CYC_LOAD) begin
						cycCnt <= sadc_pkg::SADC_CYC_RESET;
						if (scanMode) begin
							state <= sadc_pkg::SADC_DESEL; // [R13]
						end else begin
							state <= sadc_pkg::SADC_IDLE; // [R1] [R12]
						end
					end else begin
						cycCnt <= cycCnt + 4'h1; // [R18]
					end
				end
				sadc_pkg::SADC_DESEL: begin
					state  <= sadc_pkg::SADC_RUN; // [R2] [R13]
					cycCnt <= sadc_pkg::SADC_CYC_SAMPLE;
				end
				default: begin
					state  <= sadc_pkg::SADC_IDLE;
					cycCnt <= sadc_pkg::SADC_CYC_RESET;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// result capture
	// ------------------------------------------------------------
	assign loadHigh = analogCtl.load;

	// new data kept pending until the load strobe is low; a new pulse wins
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			heldData <= 8'h00;
			heldNew  <= 1'b0;
		end else if (convDone) begin
			heldData <= convData;
			heldNew  <= 1'b1;
		end else if (!loadHigh) begin
			heldNew  <= 1'b0;
		end
	end

	// result content after reset left as is [R3]
	always_ff @(posedge mclk) begin
		if (heldNew && !loadHigh) begin
			conversion_result_reg <= heldData; // [R2] [R14]
		end
	end

	// ------------------------------------------------------------
	// analog controls
	// ------------------------------------------------------------
	assign seqLive = !psPrev && !stopReq && state == sadc_pkg::SADC_RUN; // [R20]

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			analogCtl <= '0; // [R3]
			convClk   <= 1'b1;
		end else begin
			convClk         <= divClk;
			analogCtl.pwrUp <= !psPrev && (state != sadc_pkg::SADC_IDLE || startReq) &&
				!stopReq; // [R11] [R12] [R20]
			analogCtl.sample <= seqLive &&
				(cycCnt == sadc_pkg::SADC_CYC_SAMPLE ||
				 cycCnt == sadc_pkg::SADC_CYC_SMPEND); // [R11] [R21]
			analogCtl.select <= seqLive &&
				cycCnt != sadc_pkg::SADC_CYC_SAMPLE; // [R11] [R13]
			analogCtl.load <= seqLive &&
				cycCnt == sadc_pkg::SADC_CYC_LOAD; // [R18]
			analogCtl.posChan <= conversion_control_reg.channel; // [R6] [R7]
			analogCtl.negChan <= conversion_control_reg.channel ^ 3'h1; // [R7] [R21]
			analogCtl.diff    <= conversion_control_reg.mode[sadc_pkg::SADC_MODE_DIFF];
		end
	end

endmodule

`default_nettype wire

// ---- testbench.sv ----
/*
 * self-checking bench of the converter sequencer: bus tasks, analog macro
 * stand-in, conversion loop over channels, single modes and prescalers.
 * assumes the design and checker files are compiled before it.
 */
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, convClk;
	logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic powerSave, convDone, smpQ, ldQ, selQ;
	logic [7:0] convData, pend, lastSent, prevSent, ctl;
	sadc_pkg::sadc_analog_type analogCtl;
	int seed = 5052;
	int miscompares = 0;
	int compares = 0;
	int smpRises = 0;
	int selFalls = 0;
	int w, t, k;

	sadc_sequencer i_dut (.mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .powerSave(powerSave), .convData(convData),
		.convDone(convDone), .analogCtl(analogCtl), .convClk(convClk));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic int div(input logic [2:0] c);
		case (c)
			3'h1: return 1;
			3'h2: return 2;
			3'h3: return 4;
			3'h4: return 6;
			3'h5: return 12;
			3'h6: return 8;
			default: return 16;
		endcase
	endfunction

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge mclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [3:0] a);
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge mclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		rd = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic close_out();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// clock, analog macro stand-in, edge counters
	// ------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		if (!rst_n) begin
			{convDone, smpQ, ldQ, selQ} <= 4'h0;
			convData <= 8'h5A;
			pend <= 8'hC3;
		end else begin
			smpQ <= analogCtl.sample;
			ldQ <= analogCtl.load;
			selQ <= analogCtl.select;
			if (analogCtl.sample && !smpQ) smpRises <= smpRises + 1;
			if (!analogCtl.select && selQ) selFalls <= selFalls + 1;
			if (analogCtl.load && !ldQ) begin
				convDone <= 1'b1;
				convData <= pend;
				prevSent <= lastSent;
				lastSent <= pend;
				pend <= $random(seed);
			end else begin
				convDone <= 1'b0;
				convData <= ~convData;
			end
		end
	end

	initial begin
		#2000000;
		miscompares++;
		close_out();
	end

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = 44'h0;
		{powerSave, rst_n} = 2'h0;
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		axi_rd(sadc_pkg::SADC_OFS_CONTROL);
		check("ctrl after reset", rd[8:0], 9'h000);
		check("power after reset", analogCtl.pwrUp, 1'b0);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			ctl = {i[2:0], ($random(seed) & 1) ? 2'h2 : 2'h0, 3'(i % 7 + 1)};
			k = smpRises;
			axi_wr(sadc_pkg::SADC_OFS_CONTROL, {24'h0, ctl}, 4'h1);
			check("bresp", r, sadc_pkg::SADC_BRESP_OK);
			while (!analogCtl.sample) @(posedge mclk);
			check("posChan", analogCtl.posChan, ctl[7:5]);
			check("diff", analogCtl.diff, ctl[4]);
			if (ctl[4]) check("negChan", analogCtl.negChan, ctl[7:5] ^ 3'h1);
			w = 0;
			while (analogCtl.sample) begin
				w++;
				@(posedge mclk);
			end
			check("sample width", w, 2 * div(ctl[2:0]));
			t = w;
			while (!analogCtl.load) begin
				t++;
				@(posedge mclk);
			end
			while (analogCtl.load) begin
				t++;
				@(posedge mclk);
			end
			check("sequence length", t, 11 * div(ctl[2:0]));
			repeat (40) @(posedge mclk);
			axi_rd(sadc_pkg::SADC_OFS_CONTROL);
			check("ctrl fields", rd[8:0], {1'b0, ctl});
			check("power down", analogCtl.pwrUp, 1'b0);
			check("one conversion", smpRises - k, 1);
			axi_rd(sadc_pkg::SADC_OFS_RESULT);
			check("result", rd[7:0], lastSent);
		end
		$display("test single done");
		axi_wr(sadc_pkg::SADC_OFS_RESULT, 32'h000000FF, 4'hF);
		check("result write resp", r, sadc_pkg::SADC_BRESP_OK);
		axi_rd(sadc_pkg::SADC_OFS_RESULT);
		check("result kept", rd[7:0], lastSent);
		axi_wr(4'hC, 32'h0, 4'hF);
		check("unmapped write", r, sadc_pkg::SADC_BRESP_ERR);
		axi_rd(4'hC);
		check("unmapped read", r, sadc_pkg::SADC_BRESP_ERR);
		k = smpRises;
		axi_wr(sadc_pkg::SADC_OFS_CONTROL, 32'h00000040, 4'h1);
		repeat (30) @(posedge mclk);
		check("zero prescaler", smpRises - k, 0);
		check("zero prescaler power", analogCtl.pwrUp, 1'b0);
		$display("test refusals done");
		k = selFalls;
		axi_wr(sadc_pkg::SADC_OFS_CONTROL, 32'h00000069, 4'h1);
		repeat (60) @(posedge mclk);
		check("deselect between", selFalls - k >= 3, 1'b1);
		axi_wr(sadc_pkg::SADC_OFS_CONTROL, 32'h000000A2, 4'h1);
		axi_rd(sadc_pkg::SADC_OFS_CONTROL);
		check("locked ctrl", rd[8:0], 9'h169);
		axi_rd(sadc_pkg::SADC_OFS_RESULT);
		check("scan result", rd[7:0] === lastSent || rd[7:0] === prevSent, 1'b1);
		powerSave <= 1'b1;
		repeat (10) @(posedge mclk);
		check("save power", analogCtl.pwrUp, 1'b0);
		k = smpRises;
		powerSave <= 1'b0;
		repeat (40) @(posedge mclk);
		check("restart", smpRises > k, 1'b1);
		axi_wr(sadc_pkg::SADC_OFS_CONTROL, 32'h0, 4'h2);
		axi_rd(sadc_pkg::SADC_OFS_CONTROL);
		check("busy cleared", rd[8], 1'b0);
		axi_wr(sadc_pkg::SADC_OFS_CONTROL, 32'h000000DF, 4'h1);
		axi_rd(sadc_pkg::SADC_OFS_CONTROL);
		check("new settings", rd[8:0], 9'h1DF);
		$display("test scan done");
		@(posedge mclk);
		rst_n <= 1'b0;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		axi_rd(sadc_pkg::SADC_OFS_CONTROL);
		check("ctrl after reset", rd[8:0], 9'h000);
		check("power after reset", analogCtl.pwrUp, 1'b0);
		$display("test second reset done");
		close_out();
	end
endmodule

bind sadc_sequencer sadc_seq_sva i_sva (.mclk(mclk), .rst_n(rst_n),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .powerSave(powerSave),
	.analogCtl(analogCtl), .convClk(convClk));

`default_nettype wire
